/* logic/adc_scan_pkg.sv */
// Constants, register map and carrier types of the converter scan sequencer.
// Assumes a 16-bit register port over byte registers and a 40 MHz core clock.
package adc_scan_pkg;

	localparam int NUM_CHANNELS = 8;
	localparam int ADDR_W       = 5;
	localparam int RESULT_W     = 10;

	// Register offsets
	localparam logic [4:0] CTRL_OFS        = 5'h00;
	localparam logic [4:0] CHSEL_OFS       = 5'h01;
	localparam logic [4:0] TIMING_OFS      = 5'h02;
	localparam logic [4:0] RESULT_LOW_OFS  = 5'h03;
	localparam logic [4:0] IRQ_STATUS_OFS  = 5'h04;
	localparam logic [4:0] IRQ_CLEAR_OFS   = 5'h05;
	localparam logic [4:0] IRQ_ENABLE_OFS  = 5'h06;
	localparam logic [4:0] PRIORITY_OFS    = 5'h07;
	localparam logic [4:0] RESULT_HIGH_OFS = 5'h08;

	// Control register fields
	localparam int CTRL_DONE_BIT  = 0;
	localparam int CTRL_START_BIT = 1;
	localparam int CTRL_MODE_BIT  = 2;
	localparam int CTRL_RES_BIT   = 3;

	// Interrupt status, clear and enable fields
	localparam int IRQ_W         = 2;
	localparam int IRQ_DONE_BIT  = 0;
	localparam int IRQ_ABORT_BIT = 1;

	// Timing register fields
	localparam int TIMING_SAMPLE_LSB = 0;
	localparam int TIMING_STEP_LSB   = 4;
	localparam logic [3:0] TIMING_DOUBLE_A = 4'h6;
	localparam logic [3:0] TIMING_DOUBLE_B = 4'hb;

	// Reset values
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [7:0] UPPER_BYTE = 8'h00;

	// Timing
	localparam int CLK_FREQ_MHZ       = 40;
	localparam int SAMPLE_UNIT_NS     = 100;
	localparam int SAMPLE_UNIT_CYCLES =
		int'((longint'(SAMPLE_UNIT_NS) * CLK_FREQ_MHZ + 999) / 1000);
	localparam logic [3:0] BITS_8  = 4'h8;
	localparam logic [3:0] BITS_10 = 4'ha;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_FIND,
		ST_SAMPLE,
		ST_CONVERT,
		ST_STORE
	} fsm_type;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [15:0]       wdata;
	} bus_req_type;

	typedef struct packed {
		logic       sample;
		logic       step;
		logic       resolution;
		logic [2:0] channel;
	} analog_ctrl_type;

endpackage

/* logic/adc_scan_sequencer.sv */
// Scan sequencer for an eight-channel successive-approximation converter.
// Assumes the analog core follows sample/step and presents its code on
// conv_data_i, MSB first aligned, when the last step has passed.
`timescale 1ns/1ps

// Behaviour
// R1 - Eight channels, one result register each
// R2 - Resolution bit selects ten or eight bits
// R3 - Ten-bit conversion takes more steps; software retimes
// R4 - Convert selected channels, skip unselected ones
// R5 - Result overwrites that channel's high register
// R6 - Ten-bit low bits go top of shared low
// R7 - Software reads low bits before next conversion
// R8 - Only writing start bit begins a scan
// R9 - Single scan converts once, flags at end
// R10 - Continuous scan repeats, flags every pass
// R11 - Interrupt needs enables and higher priority
// R12 - Done flag cleared only by software
// R13 - Hardware set survives read-modify-write clear
// R14 - Byte registers; wide write uses low byte
// R15 - Timing sets sample time; 6, B double
// R16 - Unimplemented bits written zero, read zero
// R17 - Start bit busy; restart ignored; clear aborts
// R18 - Ascending channel order, restart each pass
// R19 - Single scan clears start bit at end
module adc_scan_sequencer
(
	// Clock and reset
	input  wire logic                          mclk_i,
	input  wire logic                          rstn_i,
	// Register port
	input  wire adc_scan_pkg::bus_req_type     bus_i,
	output logic [15:0]                        rdata_o,
	// Interrupt system context
	input  wire logic                          global_irq_enable_i,
	input  wire logic [3:0]                    running_priority_i,
	input  wire logic [3:0]                    pending_priority_i,
	output logic                               irq_o,
	// Analog core
	output adc_scan_pkg::analog_ctrl_type      analog_o,
	input  wire logic [adc_scan_pkg::RESULT_W-1:0] conv_data_i
);

	typedef struct packed {
		adc_scan_pkg::fsm_type                 fsm;
		logic                                  resolution;
		logic                                  continuous;
		logic                                  start;
		logic                                  done;
		logic                                  done_since_read;
		logic [7:0]                            chsel;
		logic [7:0]                            timing;
		logic [7:0]                            result_low;
		logic [7:0][7:0]                       result_high;
		logic [adc_scan_pkg::IRQ_W-1:0]        irq_status;
		logic [adc_scan_pkg::IRQ_W-1:0]        irq_enable;
		logic [3:0]                            irq_level;
		logic [3:0]                            ptr;
		logic [2:0]                            chan;
		logic [7:0]                            sample_cnt;
		logic [3:0]                            step_div;
		logic [3:0]                            bits_left;
		logic [7:0]                            rdata;
	} state_type;

	state_type r;
	state_type next_r;

	// Lowest selected channel at or above from; NUM_CHANNELS when none
	function automatic logic [3:0] next_channel(input logic [7:0] sel, input logic [3:0] from);
		logic [3:0] found;
		found = 4'h8;
		for (int i = adc_scan_pkg::NUM_CHANNELS - 1; i >= 0; i--)
		begin
			if (sel[i] && (4'(i) >= from))
				found = 4'(i);
		end
		return found;
	endfunction

	// Sample length scales with the low nibble; two codes double it
	function automatic logic [7:0] sample_len(input logic [7:0] timing);
		logic [3:0] code;
		logic [7:0] len;
		code = timing[adc_scan_pkg::TIMING_SAMPLE_LSB +: 4];
		len  = 8'((int'(code) + 1) * adc_scan_pkg::SAMPLE_UNIT_CYCLES);
		if (code == adc_scan_pkg::TIMING_DOUBLE_A || code == adc_scan_pkg::TIMING_DOUBLE_B)
			len = 8'(len << 1);
		return len;
	endfunction

	logic [3:0] found;
	logic       step_pulse;
	logic       hw_done;
	logic       hw_abort;
	logic [7:0] wbyte;

	always_comb
	begin
		next_r     = r;
		found      = next_channel(r.chsel, r.ptr);
		step_pulse = (r.fsm == adc_scan_pkg::ST_CONVERT) && (r.step_div == 4'h0);
		hw_done    = 1'b0;
		hw_abort   = 1'b0;
		// Only the low byte of a wide write lands
		wbyte      = bus_i.wdata[7:0]; // R14

		unique case (r.fsm)
			adc_scan_pkg::ST_IDLE:
			begin
				next_r.fsm = adc_scan_pkg::ST_IDLE;
			end
			adc_scan_pkg::ST_FIND:
			begin
				if (found == 4'h8)
				begin
					// Pass over: every selected channel has been converted once
					hw_done = 1'b1; // R9 R10
					// Empty selection would spin, so it ends the scan even when continuous
					if (r.continuous && (r.chsel != adc_scan_pkg::BYTE_RESET))
						next_r.ptr = 4'h0; // R10 R18
					else
					begin
						next_r.start = 1'b0; // R19
						next_r.fsm   = adc_scan_pkg::ST_IDLE;
					end
				end
				else
				begin
					next_r.chan       = found[2:0]; // R4 R18
					next_r.sample_cnt = sample_len(r.timing); // R15
					next_r.fsm        = adc_scan_pkg::ST_SAMPLE;
				end
			end
			adc_scan_pkg::ST_SAMPLE:
			begin
				next_r.sample_cnt = r.sample_cnt - 8'h01;
				if (r.sample_cnt <= 8'h01)
				begin
					next_r.fsm       = adc_scan_pkg::ST_CONVERT;
					next_r.step_div  = r.timing[adc_scan_pkg::TIMING_STEP_LSB +: 4];
					next_r.bits_left = r.resolution ? adc_scan_pkg::BITS_10
						: adc_scan_pkg::BITS_8; // R2 R3
				end
			end
			adc_scan_pkg::ST_CONVERT:
			begin
				// Divider gives one step enable per bit decision
				if (step_pulse)
				begin
					next_r.step_div  = r.timing[adc_scan_pkg::TIMING_STEP_LSB +: 4];
					next_r.bits_left = r.bits_left - 4'h1;
					if (r.bits_left == 4'h1)
						next_r.fsm = adc_scan_pkg::ST_STORE;
				end
				else
					next_r.step_div = r.step_div - 4'h1;
			end
			adc_scan_pkg::ST_STORE:
			begin
				next_r.result_high[r.chan] = conv_data_i[9:2]; // R1 R5
				if (r.resolution)
					next_r.result_low = {conv_data_i[1:0], 6'h00}; // R6
				next_r.ptr = {1'b0, r.chan} + 4'h1;
				next_r.fsm = adc_scan_pkg::ST_FIND;
			end
			default:
			begin
				next_r.fsm = adc_scan_pkg::ST_IDLE;
			end
		endcase

		// Register reads; data appear one cycle later
		if (bus_i.rd)
		begin
			unique case (bus_i.addr)
				adc_scan_pkg::CTRL_OFS:
				begin
					next_r.rdata = {4'h0, r.resolution, r.continuous, r.start, r.done}; // R16
					next_r.done_since_read = 1'b0;
				end
				adc_scan_pkg::CHSEL_OFS:       next_r.rdata = r.chsel;
				adc_scan_pkg::TIMING_OFS:      next_r.rdata = r.timing;
				adc_scan_pkg::RESULT_LOW_OFS:  next_r.rdata = r.result_low;
				adc_scan_pkg::IRQ_STATUS_OFS:  next_r.rdata = {6'h00, r.irq_status};
				adc_scan_pkg::IRQ_ENABLE_OFS:  next_r.rdata = {6'h00, r.irq_enable};
				adc_scan_pkg::PRIORITY_OFS:    next_r.rdata = {4'h0, r.irq_level};
				default:
				begin
					if (bus_i.addr[4:3] == adc_scan_pkg::RESULT_HIGH_OFS[4:3])
						next_r.rdata = r.result_high[bus_i.addr[2:0]]; // R1
					else
						next_r.rdata = adc_scan_pkg::BYTE_RESET;
				end
			endcase
		end

		// Register writes
		if (bus_i.wr)
		begin
			unique case (bus_i.addr)
				adc_scan_pkg::CTRL_OFS:
				begin
					next_r.resolution = wbyte[adc_scan_pkg::CTRL_RES_BIT];
					next_r.continuous = wbyte[adc_scan_pkg::CTRL_MODE_BIT];
					// Writing start while idle is the only way in
					if (wbyte[adc_scan_pkg::CTRL_START_BIT] && !r.start)
					begin
						next_r.start = 1'b1; // R8
						next_r.ptr   = 4'h0; // R18
						next_r.fsm   = adc_scan_pkg::ST_FIND;
					end
					else if (!wbyte[adc_scan_pkg::CTRL_START_BIT] && r.start)
					begin
						next_r.start = 1'b0; // R17
						next_r.fsm   = adc_scan_pkg::ST_IDLE;
						hw_abort     = 1'b1;
					end
					// Clear lands only if no set slipped in since the last read
					if (!wbyte[adc_scan_pkg::CTRL_DONE_BIT] && !r.done_since_read)
						next_r.done = 1'b0; // R12 R13
				end
				adc_scan_pkg::CHSEL_OFS:      next_r.chsel = wbyte;
				adc_scan_pkg::TIMING_OFS:     next_r.timing = wbyte; // R3 R15
				adc_scan_pkg::IRQ_CLEAR_OFS:
					next_r.irq_status = r.irq_status & ~wbyte[adc_scan_pkg::IRQ_W-1:0];
				adc_scan_pkg::IRQ_ENABLE_OFS: next_r.irq_enable = wbyte[adc_scan_pkg::IRQ_W-1:0];
				adc_scan_pkg::PRIORITY_OFS:   next_r.irq_level = wbyte[3:0];
				default:
				begin
					next_r.fsm = next_r.fsm;
				end
			endcase
		end

		// Hardware sets win over any clear in the same cycle
		if (hw_done)
		begin
			next_r.done            = 1'b1; // R12 R13
			next_r.done_since_read = 1'b1; // R13
			next_r.irq_status[adc_scan_pkg::IRQ_DONE_BIT] = 1'b1;
		end
		if (hw_abort)
			next_r.irq_status[adc_scan_pkg::IRQ_ABORT_BIT] = 1'b1;
	end

	always_ff @(posedge mclk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			r.fsm             <= adc_scan_pkg::ST_IDLE;
			r.resolution      <= 1'b0;
			r.continuous      <= 1'b0;
			r.start           <= 1'b0;
			r.done            <= 1'b0;
			r.done_since_read <= 1'b0;
			r.chsel           <= adc_scan_pkg::BYTE_RESET;
			r.timing          <= adc_scan_pkg::BYTE_RESET;
			r.result_low      <= adc_scan_pkg::BYTE_RESET;
			r.result_high     <= '0;
			r.irq_status      <= '0;
			r.irq_enable      <= '0;
			r.irq_level       <= 4'h0;
			r.ptr             <= 4'h0;
			r.chan            <= 3'h0;
			r.sample_cnt      <= 8'h00;
			r.step_div        <= 4'h0;
			r.bits_left       <= 4'h0;
			r.rdata           <= adc_scan_pkg::BYTE_RESET;
		end
		else
			r <= next_r;
	end

	// Upper byte of a wide read is not defined; it reads as zero here
	assign rdata_o = {adc_scan_pkg::UPPER_BYTE, r.rdata}; // R14

	// Priority must beat both running code and any pending request
	assign irq_o = global_irq_enable_i && |(r.irq_status & r.irq_enable)
		&& (r.irq_level > running_priority_i)
		&& (r.irq_level > pending_priority_i); // R11

	assign analog_o.sample     = (r.fsm == adc_scan_pkg::ST_SAMPLE);
	assign analog_o.step       = step_pulse;
	assign analog_o.resolution = r.resolution;
	assign analog_o.channel    = r.chan;

endmodule

/* testbench/adc_scan_sva.sv */
// Port-level checks of the converter scan sequencer.
// Bound onto the sequencer; sees only its ports.
`timescale 1ns/1ps
module adc_scan_sva
(
	// Clock and reset
	input wire logic                          mclk_i,
	input wire logic                          rstn_i,
	// Register port
	input wire adc_scan_pkg::bus_req_type     bus_i,
	input wire logic [15:0]                   rdata_o,
	// Interrupt context
	input wire logic                          global_irq_enable_i,
	input wire logic [3:0]                    running_priority_i,
	input wire logic [3:0]                    pending_priority_i,
	input wire logic                          irq_o,
	// Analog core
	input wire adc_scan_pkg::analog_ctrl_type analog_o,
	input wire logic [9:0]                    conv_data_i
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);

	a_upper_byte_zero: assert property (bus_i.rd |=> rdata_o[15:8] == 8'h00)
	else $error("upper read byte not zero");
	a_unmapped_read_zero: assert property (bus_i.rd && bus_i.addr[4] |=> rdata_o == 16'h0000)
	else $error("unmapped read not zero");
	a_irq_needs_global: assert property (irq_o |-> global_irq_enable_i)
	else $error("interrupt without global enable");
	a_irq_priority_room:
		assert property (irq_o |-> running_priority_i != 4'hf && pending_priority_i != 4'hf)
	else $error("interrupt without higher priority");
	a_step_not_sampling: assert property (analog_o.step |-> !analog_o.sample)
	else $error("step during sampling");
	a_sample_minimum: assert property ($rose(analog_o.sample) |-> analog_o.sample[*4])
	else $error("sample window too short");
	a_channel_held:
		assert property (analog_o.sample ##1 analog_o.sample |-> $stable(analog_o.channel))
	else $error("channel moved while sampling");
	a_convert_follows: assert property ($fell(analog_o.sample) |-> ##[0:16] analog_o.step)
	else $error("no conversion step after sampling");
endmodule

bind adc_scan_sequencer adc_scan_sva adc_scan_sva_inst
(
	.mclk_i              (mclk_i),
	.rstn_i              (rstn_i),
	.bus_i               (bus_i),
	.rdata_o             (rdata_o),
	.global_irq_enable_i (global_irq_enable_i),
	.running_priority_i  (running_priority_i),
	.pending_priority_i  (pending_priority_i),
	.irq_o               (irq_o),
	.analog_o            (analog_o),
	.conv_data_i         (conv_data_i)
);

/* testbench/testbench.sv */
// Self-checking bench of the converter scan sequencer.
// Code on conv_data_i follows the channel so each result names its channel.
`timescale 1ns/1ps
module testbench;
	logic                          mclk_i;
	logic                          rstn_i;
	adc_scan_pkg::bus_req_type     bus_i;
	logic [15:0]                   rdata_o;
	logic                          global_irq_enable_i;
	logic [3:0]                    running_priority_i;
	logic [3:0]                    pending_priority_i;
	logic                          irq_o;
	adc_scan_pkg::analog_ctrl_type analog_o;
	logic [9:0]                    conv_data_i;
	int                            err_total = 0;
	int                            comparisons = 0;
	int                            cycles = 0;
	int                            steps = 0;
	int                            run = 0;
	int                            slen = 0;
	int                            s0;
	logic [2:0]                    last_ch = 3'h0;
	logic [15:0]                   d;

	adc_scan_sequencer adc_scan_sequencer_inst
	(
		.mclk_i              (mclk_i),
		.rstn_i              (rstn_i),
		.bus_i               (bus_i),
		.rdata_o             (rdata_o),
		.global_irq_enable_i (global_irq_enable_i),
		.running_priority_i  (running_priority_i),
		.pending_priority_i  (pending_priority_i),
		.irq_o               (irq_o),
		.analog_o            (analog_o),
		.conv_data_i         (conv_data_i)
	);

	initial
	begin
		mclk_i = 1'b0;
		forever #12.5 mclk_i = ~mclk_i;
	end

	// Step count, sample length and last channel, for comparison after a scan
	always @(posedge mclk_i)
	begin
		conv_data_i <= {analog_o.channel, 7'h55};
		cycles <= cycles + 1;
		if (analog_o.step)
			steps <= steps + 1;
		if (analog_o.sample)
		begin
			run <= run + 1;
			last_ch <= analog_o.channel;
		end
		else if (run != 0)
		begin
			slen <= run;
			run <= 0;
		end
		if (cycles == 20000)
		begin
			err_total++;
			finish_test();
		end
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_total++;
			$display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [15:0] v);
		@(posedge mclk_i);
		bus_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
		@(posedge mclk_i);
		bus_i <= '0;
	endtask

	task automatic rd(input logic [4:0] a);
		@(posedge mclk_i);
		bus_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(posedge mclk_i);
		bus_i <= '0;
		#1 d = rdata_o;
	endtask

	task automatic rc(input logic [4:0] a, input logic [15:0] exp);
		rd(a);
		chk(d, exp);
	endtask

	// Polls the control register; the run timeout bounds the wait
	task automatic wait_ctrl(input int b, input logic v);
		rd(adc_scan_pkg::CTRL_OFS);
		while (d[b] !== v)
			rd(adc_scan_pkg::CTRL_OFS);
	endtask

	task automatic irq_case(input logic g, input logic [3:0] r, input logic [3:0] p);
		global_irq_enable_i <= g;
		running_priority_i <= r;
		pending_priority_i <= p;
		@(posedge mclk_i);
		#1 d = {15'h0000, irq_o};
	endtask

	task automatic finish_test();
		if (err_total == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial
	begin
		rstn_i = 1'b0;
		bus_i = '0;
		global_irq_enable_i = 1'b0;
		running_priority_i = 4'h0;
		pending_priority_i = 4'h0;
		repeat (5) @(posedge mclk_i);
		rstn_i <= 1'b1;
		for (int a = 0; a < 32; a++)
			rc(5'(a), 16'h0000);
		// Single eight-bit scan of channels 0 and 2; wide write keeps low byte
		wr(5'h01, 16'hab05);
		rc(5'h01, 16'h0005);
		s0 = steps;
		wr(5'h00, 16'h0002);
		wait_ctrl(1, 1'b0);
		rc(5'h00, 16'h0001);
		rc(5'h04, 16'h0001);
		chk(16'(steps - s0), 16'h0010);
		chk({13'h0000, last_ch}, 16'h0002);
		rc(5'h08, 16'h0015);
		rc(5'h09, 16'h0000);
		rc(5'h0a, 16'h0055);
		rc(5'h03, 16'h0000);
		// Interrupt gating by enables and strict priority
		wr(5'h06, 16'h0001);
		wr(5'h07, 16'h0005);
		irq_case(1'b1, 4'h4, 4'h4);
		chk(d, 16'h0001);
		irq_case(1'b1, 4'h5, 4'h4);
		chk(d, 16'h0000);
		irq_case(1'b1, 4'h4, 4'h5);
		chk(d, 16'h0000);
		irq_case(1'b0, 4'h4, 4'h4);
		chk(d, 16'h0000);
		wr(5'h06, 16'h0000);
		irq_case(1'b1, 4'h4, 4'h4);
		chk(d, 16'h0000);
		wr(5'h06, 16'h0001);
		wr(5'h05, 16'h0001);
		irq_case(1'b1, 4'h4, 4'h4);
		chk(d, 16'h0000);
		rc(5'h04, 16'h0000);
		rc(5'h00, 16'h0001);
		wr(5'h00, 16'h0000);
		rc(5'h00, 16'h0000);
		// Ten-bit scan of channel 7 with doubled sample time
		wr(5'h02, 16'h0006);
		wr(5'h01, 16'h0080);
		s0 = steps;
		wr(5'h00, 16'h000a);
		wait_ctrl(1, 1'b0);
		chk(16'(steps - s0), 16'h000a);
		chk(16'(slen), 16'h0038);
		chk({15'h0000, analog_o.resolution}, 16'h0001);
		rc(5'h0f, 16'h00f5);
		rc(5'h03, 16'h0040);
		rc(5'h00, 16'h0009);
		// Continuous scan, then abort in mid-conversion
		wr(5'h02, 16'h0000);
		wr(5'h01, 16'h0003);
		wr(5'h00, 16'h0006);
		wait_ctrl(0, 1'b1);
		rd(5'h00);
		chk(d & 16'h0006, 16'h0006);
		while (analog_o.step !== 1'b1)
			@(posedge mclk_i);
		wr(5'h00, 16'h0000);
		repeat (2) @(posedge mclk_i);
		#1 s0 = steps;
		repeat (40) @(posedge mclk_i);
		chk(16'(steps - s0), 16'h0000);
		rd(5'h00);
		chk(d & 16'h0002, 16'h0000);
		rc(5'h04, 16'h0003);
		finish_test();
	end
endmodule
